// ==== logic/cfg_mirror.sv ====
// Second copy of the frozen configuration, standing for the far die.
// Assumes the owner captures it whenever the frozen set changes.
`timescale 1ns/1ps
module cfg_mirror #(
  parameter int W = 144
) (
  // Clock and reset.
  input  wire logic         i_mclk,
  input  wire logic         i_srst,
  // Capture and disturbance.
  input  wire logic         i_capture,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_upset,
  // Stored copy.
  output logic      [W-1:0] o_data
);
  logic [W-1:0] copy_r;
  logic [W-1:0] copy_nxt;

  if (W < 1) begin : g_bad_w
    $error("cfg_mirror needs a positive width.");
  end

  // A capture loads the copy; an upset flips its lowest bit.
  always_comb begin
    copy_nxt = copy_r;
    if (i_capture) begin
      copy_nxt = i_data;
    end else if (i_upset) begin
      copy_nxt[0] = ~copy_r[0];
    end
  end

  // The copy is read straight out of its register.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      copy_r <= '0;
    end else begin
      copy_r <= copy_nxt;
    end
  end

  assign o_data = copy_r;
endmodule // cfg_mirror

// ==== logic/clamp_activation_timer.sv ====
// Times the active clamp window after hard commutation.
// Assumes one-cycle event strobes synchronous to i_mclk.
`timescale 1ns/1ps
module clamp_activation_timer #(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset.
  input  wire logic       i_mclk,
  input  wire logic       i_srst,
  // Setting and events.
  input  wire logic [7:0] i_time,
  input  wire logic       i_hard_comm,
  input  wire logic       i_turn_on,
  // Clamp disable level.
  output logic            o_clamp_disable
);
  localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [PW-1:0] PLAST = PW'(TICK_CYCLES - 1);

  logic          run_r, run_nxt;
  logic [7:0]    left_r, left_nxt;
  logic [PW-1:0] pre_r, pre_nxt;
  logic          out_r, out_nxt;

  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one.");
  end

  // Start on commutation, restart on a turn-on pulse inside the window.
  always_comb begin
    run_nxt  = run_r;
    left_nxt = left_r;
    pre_nxt  = pre_r;
    if (i_hard_comm || (run_r && i_turn_on)) begin
      run_nxt  = 1'b1;
      left_nxt = i_time;
      pre_nxt  = '0;
    end else if (run_r) begin
      if (pre_r == PLAST) begin
        pre_nxt  = '0;
        left_nxt = left_r - 8'h01;
        run_nxt  = (left_r > 8'h01);
      end else begin
        pre_nxt = pre_r + PW'(1);
      end
    end
    if (i_time == 8'h00) begin
      out_nxt = 1'b1;
    end else if (i_time == 8'hFF) begin
      out_nxt = 1'b0;
    end else begin
      out_nxt = ~run_nxt;
    end
  end

  // Timer state; the clamp stays disabled out of reset.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      run_r  <= 1'b0;
      left_r <= 8'h00;
      pre_r  <= '0;
      out_r  <= 1'b1;
    end else begin
      run_r  <= run_nxt;
      left_r <= left_nxt;
      pre_r  <= pre_nxt;
      out_r  <= out_nxt;
    end
  end

  assign o_clamp_disable = out_r;

  a_clamp_const_hi : assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_time == 8'h00)[*2] |-> o_clamp_disable)
    else $error("Clamp disable not high for a zero time.");

  a_clamp_retrig : assert property (@(posedge i_mclk) disable iff (i_srst)
    (run_r && i_turn_on && !i_hard_comm) |=> (left_r == $past(i_time)))
    else $error("Turn-on inside the window did not restart it.");
endmodule // clamp_activation_timer

// ==== logic/gate_driver_static_config.sv ====
// Static configuration bank of an isolated gate driver: mode control,
// freezing, cross-die check, parity, clamp timing and delay calibration.
// Assumes synchronous strobes and a master that never waits.
// Overview of operation
// - Static writes accepted only in configuration mode.
// - Exit command freezes settings, later writes dropped.
// - Copy mismatch raises reset and class B.
// - Odd receive parity checked when enabled.
// - Transmit parity bit always generated.
// - Emitter compensation follows its enable bit.
// - Desat clamp in off state when enabled.
// - Pulse suppressor follows its enable bit.
// - Verify timeout follows its select bit.
// - Zero soft-off delay means hard turn-off.
// - Desat blanking from either blanking field.
// - Zero overcurrent blanking reacts immediately.
// - Clamp disable constant at zero or all ones.
// - Turn-on restarts a running clamp timer.
// - PWM-gated oscillator count sets regular delay.
// - Reset event restores defaults and default mode.
`timescale 1ns/1ps
`include "gdcfg_map.svh"
module gate_driver_static_config import gdcfg_pkg::*; #(
  parameter int CLAMP_TICK_CYCLES = 4
) (
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  // Register port.
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // Serial words.
  input  wire logic [15:0] i_rx_word,
  input  wire logic        i_rx_valid,
  output logic             o_rx_parity_err,
  input  wire logic [14:0] i_tx_data,
  input  wire logic        i_tx_valid,
  output logic      [15:0] o_tx_word,
  // Device events and output stage status.
  input  wire logic        i_reset_event,
  input  wire logic        i_mirror_upset,
  input  wire logic        i_output_off,
  input  wire logic        i_blanking,
  input  wire logic        i_blank_select,
  input  wire logic        i_hard_comm,
  input  wire logic        i_turn_on,
  input  wire logic        i_pwm,
  input  wire logic        i_osc_tick,
  // Results.
  output logic             o_reset_event,
  output logic             o_class_b,
  output logic             o_emitter_comp_en,
  output logic             o_pulse_suppress_en,
  output logic             o_verify_timeout_sel,
  output logic             o_desat_clamp,
  output logic             o_regular_hard_off,
  output logic             o_safe_hard_off,
  output logic      [7:0]  o_desat_blank_time,
  output logic      [7:0]  o_ocp_blank_time,
  output logic             o_ocp_immediate,
  output logic             o_clamp_disable
);
  localparam int NREG = 9;
  localparam int VW   = NREG * 16;

  op_mode_t    mode_r, mode_nxt;
  logic        frozen_r, frozen_nxt;
  logic [15:0] cfg_r   [1:NREG];
  logic [15:0] cfg_nxt [1:NREG];
  logic [VW-1:0] cfg_vec, cfg_nxt_vec, mirror_q;
  logic        class_b_r, class_b_nxt;
  logic        reject_r, reject_nxt;
  logic        rst_evt_r, rst_evt_nxt;
  logic        cal_run_r, cal_run_nxt;
  logic        cal_done_r, cal_done_nxt;
  logic [7:0]  cal_cnt_r, cal_cnt_nxt;
  logic        pwm_d_r;
  logic        mismatch, capture, cal_store;
  logic [15:0] rdata_r, rdata_nxt;

  if (CLAMP_TICK_CYCLES < 1) begin : g_bad_tick
    $error("CLAMP_TICK_CYCLES must be at least one.");
  end

  // Writable bits of each configuration register.
  function automatic logic [15:0] wmask(input logic [3:0] idx);
    unique case (idx)
      `CFG_OFS_PARITY:   wmask = `CFG_MASK_PARITY;
      `CFG_OFS_STATIC:   wmask = `CFG_MASK_STATIC;
      `CFG_OFS_REG_OFF,
      `CFG_OFS_SAFE_OFF: wmask = `CFG_MASK_SOFT;
      `CFG_OFS_CAL:      wmask = `CFG_MASK_CAL;
      default:           wmask = `CFG_MASK_BYTE;
    endcase
  endfunction

  // Default value of each configuration register.
  function automatic logic [15:0] rstval(input int idx);
    rstval = (idx == 1) ? `CFG_RST_PARITY : `CFG_RST_OTHER;
  endfunction

  // Flatten the bank for the cross-die copy.
  for (genvar k = 1; k <= NREG; k++) begin : g_vec
    assign cfg_vec[(k-1)*16 +: 16]     = cfg_r[k];
    assign cfg_nxt_vec[(k-1)*16 +: 16] = cfg_nxt[k];
  end

  cfg_mirror #(.W(VW)) u_mirror (
    .i_mclk    (i_mclk),
    .i_srst    (i_srst),
    .i_capture (capture),
    .i_data    (cfg_nxt_vec),
    .i_upset   (i_mirror_upset),
    .o_data    (mirror_q)
  );

  assign mismatch = frozen_r && (mirror_q != cfg_vec);

  // Mode, freeze, configuration writes and calibration.
  always_comb begin
    mode_nxt     = mode_r;
    frozen_nxt   = frozen_r;
    cfg_nxt      = cfg_r;
    class_b_nxt  = class_b_r || mismatch;
    reject_nxt   = reject_r;
    rst_evt_nxt  = mismatch;
    cal_run_nxt  = cal_run_r;
    cal_done_nxt = cal_done_r;
    cal_cnt_nxt  = cal_cnt_r;
    cal_store    = 1'b0;
    if (i_rd && i_addr == `CFG_OFS_MODE) begin
      reject_nxt = 1'b0;
    end
    if (i_reset_event || mismatch) begin
      mode_nxt     = default_op_mode;
      frozen_nxt   = 1'b0;
      cal_run_nxt  = 1'b0;
      cal_done_nxt = 1'b0;
      cal_cnt_nxt  = 8'h00;
      for (int k = 1; k <= NREG; k++) begin
        cfg_nxt[k] = rstval(k);
      end
    end else begin
      if (i_wr && i_addr == `CFG_OFS_MODE) begin
        unique case (mode_r)
          default_op_mode:
            if (i_wdata == `CMD_ENTER_CFG) begin
              mode_nxt = configuration_op_mode;
            end
          configuration_op_mode:
            if (i_wdata == `CMD_EXIT_CFG) begin
              mode_nxt   = normal_op_mode;
              frozen_nxt = 1'b1;
            end else if (i_wdata == `CMD_ENTER_CAL) begin
              mode_nxt   = calibration_op_mode;
              frozen_nxt = 1'b1;
            end
          calibration_op_mode:
            if (i_wdata == `CMD_EXIT_CFG) begin
              mode_nxt = normal_op_mode;
            end
          normal_op_mode: ;
        endcase
      end else if (i_wr && i_addr >= `CFG_OFS_PARITY &&
                   i_addr <= `CFG_OFS_CAL) begin
        if (mode_r == configuration_op_mode && !frozen_r) begin
          cfg_nxt[i_addr] = i_wdata & wmask(i_addr);
        end else begin
          reject_nxt = 1'b1;
        end
      end
      // Oscillator ticks counted while the PWM input is high.
      if (mode_r == calibration_op_mode && cfg_r[9][0]) begin
        if (i_pwm && !pwm_d_r) begin
          cal_run_nxt = 1'b1;
          cal_cnt_nxt = 8'h00;
        end else if (cal_run_r && !i_pwm) begin
          cal_run_nxt  = 1'b0;
          cal_done_nxt = 1'b1;
          cal_store    = 1'b1;
          cfg_nxt[3]   = {cfg_r[3][15:8], cal_cnt_r};
        end else if (cal_run_r && i_osc_tick && cal_cnt_r != 8'hFF) begin
          cal_cnt_nxt = cal_cnt_r + 8'h01;
        end
      end
    end
  end

  // The copy follows every change of the frozen set.
  assign capture = (frozen_nxt && !frozen_r) || cal_store;

  // Control and configuration registers.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      mode_r     <= default_op_mode;
      frozen_r   <= 1'b0;
      class_b_r  <= 1'b0;
      reject_r   <= 1'b0;
      rst_evt_r  <= 1'b0;
      cal_run_r  <= 1'b0;
      cal_done_r <= 1'b0;
      cal_cnt_r  <= 8'h00;
      pwm_d_r    <= 1'b0;
      for (int k = 1; k <= NREG; k++) begin
        cfg_r[k] <= rstval(k);
      end
    end else begin
      mode_r     <= mode_nxt;
      frozen_r   <= frozen_nxt;
      class_b_r  <= class_b_nxt;
      reject_r   <= reject_nxt;
      rst_evt_r  <= rst_evt_nxt;
      cal_run_r  <= cal_run_nxt;
      cal_done_r <= cal_done_nxt;
      cal_cnt_r  <= cal_cnt_nxt;
      pwm_d_r    <= i_pwm;
      cfg_r      <= cfg_nxt;
    end
  end

  // Read data valid only in the cycle after the read strobe.
  always_comb begin
    rdata_nxt = 16'h0000;
    if (i_rd) begin
      if (i_addr == `CFG_OFS_MODE) begin
        rdata_nxt[1:0]              = mode_r;
        rdata_nxt[`CFG_STA_FROZEN]  = frozen_r;
        rdata_nxt[`CFG_STA_CLASSB]  = class_b_r;
        rdata_nxt[`CFG_STA_REJECT]  = reject_r;
        rdata_nxt[`CFG_STA_CALDONE] = cal_done_r;
      end else if (i_addr <= `CFG_OFS_CAL) begin
        rdata_nxt = cfg_r[i_addr];
      end
    end
  end

  // Outputs taken from the settings and the serial words.
  logic        par_err_r, par_err_nxt;
  logic [15:0] tx_r, tx_nxt;
  logic [7:0]  dblank_r, dblank_nxt;
  logic        dclamp_r, dclamp_nxt;
  always_comb begin
    par_err_nxt = i_rx_valid && cfg_r[1][0] && !(^i_rx_word);
    tx_nxt      = i_tx_valid ? {~(^i_tx_data), i_tx_data} : tx_r;
    dblank_nxt  = i_blank_select ? cfg_r[6][7:0] : cfg_r[5][7:0];
    dclamp_nxt  = i_blanking ||
                  (cfg_r[2][`CFG_BIT_DCLAMP] && i_output_off);
  end

  // Output registers.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_r   <= 16'h0000;
      par_err_r <= 1'b0;
      tx_r      <= 16'h0000;
      dblank_r  <= 8'h00;
      dclamp_r  <= 1'b1;
    end else begin
      rdata_r   <= rdata_nxt;
      par_err_r <= par_err_nxt;
      tx_r      <= tx_nxt;
      dblank_r  <= dblank_nxt;
      dclamp_r  <= dclamp_nxt;
    end
  end

  // Outputs driven from their registers; the hard-off and immediate flags decoded from them.
  assign o_rdata              = rdata_r;
  assign o_rx_parity_err      = par_err_r;
  assign o_tx_word            = tx_r;
  assign o_reset_event        = rst_evt_r;
  assign o_class_b            = class_b_r;
  assign o_emitter_comp_en    = cfg_r[2][`CFG_BIT_EMIT];
  assign o_pulse_suppress_en  = cfg_r[2][`CFG_BIT_PSUP];
  assign o_verify_timeout_sel = cfg_r[2][`CFG_BIT_TOSEL];
  assign o_desat_clamp        = dclamp_r;
  assign o_regular_hard_off   = (cfg_r[3][7:0] == 8'h00);
  assign o_safe_hard_off      = (cfg_r[4][7:0] == 8'h00);
  assign o_desat_blank_time   = dblank_r;
  assign o_ocp_blank_time     = cfg_r[7][7:0];
  assign o_ocp_immediate      = (cfg_r[7][7:0] == 8'h00);

  clamp_activation_timer #(.TICK_CYCLES(CLAMP_TICK_CYCLES)) u_clamp (
    .i_mclk          (i_mclk),
    .i_srst          (i_srst),
    .i_time          (cfg_r[8][7:0]),
    .i_hard_comm     (i_hard_comm),
    .i_turn_on       (i_turn_on),
    .o_clamp_disable (o_clamp_disable)
  );

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  a_write_locked : assert property (
    (i_wr && i_addr == `CFG_OFS_PARITY && mode_r != configuration_op_mode
     && !i_reset_event && !mismatch) |=> $stable(cfg_r[1]))
    else $error("Static write taken outside configuration mode.");
  a_exit_freezes : assert property (
    (i_wr && i_addr == `CFG_OFS_MODE && i_wdata == `CMD_EXIT_CFG &&
     mode_r == configuration_op_mode && !i_reset_event)
    |=> frozen_r && mode_r == normal_op_mode)
    else $error("Exit command did not freeze the settings.");
  a_mismatch_evt : assert property (
    mismatch |=> o_reset_event && o_class_b && !frozen_r)
    else $error("Copy mismatch raised no reset and class B.");
  a_rx_parity : assert property (
    (i_rx_valid && cfg_r[1][0] && !(^i_rx_word)) |=> o_rx_parity_err)
    else $error("Even receive word not flagged.");
  a_tx_parity : assert property (
    i_tx_valid |=> (^o_tx_word) && o_tx_word[14:0] == $past(i_tx_data))
    else $error("Transmit word lacks odd parity.");
  a_desat_clamp : assert property (
    (i_blanking || (cfg_r[2][`CFG_BIT_DCLAMP] && i_output_off))
    |=> o_desat_clamp)
    else $error("Desat pin not clamped when due.");
  a_cal_store : assert property (
    (mode_r == calibration_op_mode && cal_run_r && !i_pwm &&
     !i_reset_event && !mismatch)
    |=> cfg_r[3][7:0] == $past(cal_cnt_r) && cal_done_r)
    else $error("Calibration count not stored as regular delay.");
  a_reset_defaults : assert property (
    i_reset_event |=> mode_r == default_op_mode && cfg_r[1] ==
    `CFG_RST_PARITY && cfg_r[8] == `CFG_RST_OTHER)
    else $error("Reset event did not restore defaults.");
  a_lock_held : assert property (
    (frozen_r && !i_reset_event && !mismatch) |=> frozen_r)
    else $error("Frozen settings unlocked without a reset event.");
endmodule // gate_driver_static_config

// ==== pkg/gdcfg_map.svh ====
// Register offsets, field positions, reset values and commands of the
// static configuration bank. Assumes a 4-bit register index, 16-bit data.
`ifndef GDCFG_MAP_SVH
`define GDCFG_MAP_SVH

`define CFG_OFS_MODE     4'h0
`define CFG_OFS_PARITY   4'h1
`define CFG_OFS_STATIC   4'h2
`define CFG_OFS_REG_OFF  4'h3
`define CFG_OFS_SAFE_OFF 4'h4
`define CFG_OFS_DSAT_A   4'h5
`define CFG_OFS_DSAT_B   4'h6
`define CFG_OFS_OCP      4'h7
`define CFG_OFS_CLAMP    4'h8
`define CFG_OFS_CAL      4'h9

`define CFG_MASK_PARITY  16'h0001
`define CFG_MASK_STATIC  16'h000F
`define CFG_MASK_SOFT    16'h0FFF
`define CFG_MASK_BYTE    16'h00FF
`define CFG_MASK_CAL     16'h0001

`define CFG_RST_PARITY   16'h0001
`define CFG_RST_OTHER    16'h0000

`define CFG_BIT_EMIT     0
`define CFG_BIT_DCLAMP   1
`define CFG_BIT_PSUP     2
`define CFG_BIT_TOSEL    3

`define CFG_STA_FROZEN   2
`define CFG_STA_CLASSB   3
`define CFG_STA_REJECT   4
`define CFG_STA_CALDONE  5

`define CMD_ENTER_CFG    16'h0001
`define CMD_EXIT_CFG     16'h0002
`define CMD_ENTER_CAL    16'h0003

`endif

// ==== pkg/gdcfg_pkg.sv ====
// Types shared by the static configuration bank.
// Assumes the offsets and fields come from gdcfg_map.svh.
package gdcfg_pkg;
  typedef enum logic [1:0] {
    default_op_mode,
    configuration_op_mode,
    normal_op_mode,
    calibration_op_mode
  } op_mode_t;
endpackage

// ==== test/host_model.sv ====
// Host model: the microcontroller that programs the configuration bank.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
module host_model (
  // Clock.
  input  wire logic        i_mclk,
  // Register port towards the device.
  output logic      [3:0]  o_addr,
  output logic      [15:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd,
  input  wire logic [15:0] i_rdata
);
  // The bus is idle at time zero.
  initial begin
    o_addr = 4'hF;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One write cycle; released lines show the inverse of the last value.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  // One read cycle; data are taken once settled in the following cycle.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(negedge i_mclk);
    d = i_rdata;
  endtask

  // Soft-off setup: safe delay above, safe plateau below the regular one.
  task automatic cfg_soft_off();
    wr(4'h3, 16'h0305);
    wr(4'h4, 16'h0208);
  endtask

  // Blanking setup: overcurrent blanking kept below both desat values.
  task automatic cfg_blank();
    wr(4'h5, 16'h0020);
    wr(4'h6, 16'h0040);
    wr(4'h7, 16'h0010);
  endtask

  // Calibration is enabled in configuration mode, then its mode entered.
  task automatic start_calib();
    wr(4'h0, 16'h0001);
    wr(4'h9, 16'h0001);
    wr(4'h0, 16'h0003);
  endtask
endmodule // host_model

// ==== test/testbench.sv ====
// Self-checking bench for the static configuration bank.
// Assumes the host model drives the register port; the bench the rest.
`timescale 1ns/1ps
module testbench;
  // Stimulus and observed signals.
  logic        i_mclk, i_srst, i_wr, i_rd, i_rx_valid, i_tx_valid;
  logic        i_reset_event, i_mirror_upset, i_output_off, i_blanking;
  logic        i_blank_select, i_hard_comm, i_turn_on, i_pwm, i_osc_tick;
  logic [3:0]  i_addr;
  logic [14:0] i_tx_data;
  logic [15:0] i_wdata, o_rdata, i_rx_word, o_tx_word, d;
  logic [7:0]  o_desat_blank_time, o_ocp_blank_time;
  logic        o_rx_parity_err, o_reset_event, o_class_b, o_emitter_comp_en;
  logic        o_pulse_suppress_en, o_verify_timeout_sel, o_desat_clamp;
  logic        o_regular_hard_off, o_safe_hard_off, o_ocp_immediate;
  logic        o_clamp_disable;
  int          failures, checked, cycles;

  gate_driver_static_config #(.CLAMP_TICK_CYCLES(2))
    i_gate_driver_static_config (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_word(i_rx_word),
    .i_rx_valid(i_rx_valid), .o_rx_parity_err(o_rx_parity_err),
    .i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid), .o_tx_word(o_tx_word),
    .i_reset_event(i_reset_event), .i_mirror_upset(i_mirror_upset),
    .i_output_off(i_output_off), .i_blanking(i_blanking),
    .i_blank_select(i_blank_select), .i_hard_comm(i_hard_comm),
    .i_turn_on(i_turn_on), .i_pwm(i_pwm), .i_osc_tick(i_osc_tick),
    .o_reset_event(o_reset_event), .o_class_b(o_class_b),
    .o_emitter_comp_en(o_emitter_comp_en),
    .o_pulse_suppress_en(o_pulse_suppress_en),
    .o_verify_timeout_sel(o_verify_timeout_sel),
    .o_desat_clamp(o_desat_clamp), .o_regular_hard_off(o_regular_hard_off),
    .o_safe_hard_off(o_safe_hard_off),
    .o_desat_blank_time(o_desat_blank_time),
    .o_ocp_blank_time(o_ocp_blank_time), .o_ocp_immediate(o_ocp_immediate),
    .o_clamp_disable(o_clamp_disable));

  host_model i_host_model (
    .i_mclk(i_mclk), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
    .o_rd(i_rd), .i_rdata(o_rdata));

  // Clock of 4 ns period.
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Short helpers for bus cycles and waiting.
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    i_host_model.wr(a, v);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    i_host_model.rd(a, d);
    chk(d, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask

  // Sends one received word and checks the parity error pulse.
  task automatic rx(input logic [15:0] w, input logic e);
    @(posedge i_mclk);
    i_rx_word <= w;
    i_rx_valid <= 1'b1;
    @(posedge i_mclk);
    i_rx_valid <= 1'b0;
    @(negedge i_mclk);
    chk({15'h0000, o_rx_parity_err}, {15'h0000, e});
  endtask

  // Sends one word for transmission and checks the framed result.
  task automatic tx(input logic [14:0] v, input logic [15:0] e);
    @(posedge i_mclk);
    i_tx_data <= v;
    i_tx_valid <= 1'b1;
    @(posedge i_mclk);
    i_tx_valid <= 1'b0;
    @(negedge i_mclk);
    chk(o_tx_word, e);
  endtask

  // Defaults after reset, an unmapped read and a refused write.
  task automatic t_defaults();
    rdc(4'h0, 16'h0000);
    rdc(4'h1, 16'h0001);
    rdc(4'hF, 16'h0000);
    chk({11'h000, o_desat_clamp, o_clamp_disable, o_regular_hard_off,
         o_safe_hard_off, o_ocp_immediate}, 16'h000F);
    wr(4'h2, 16'h000F);
    rdc(4'h2, 16'h0000);
    rdc(4'h0, 16'h0010);
    rdc(4'h0, 16'h0000);
  endtask

  // Static bits, soft-off delays, blanking and parity in config mode.
  task automatic t_config();
    wr(4'h0, 16'h0001);
    wr(4'h2, 16'h000F);
    cyc(0);
    chk({13'h0000, o_emitter_comp_en, o_pulse_suppress_en,
         o_verify_timeout_sel}, 16'h0007);
    @(posedge i_mclk);
    i_output_off <= 1'b1;
    cyc(2);
    chk({15'h0000, o_desat_clamp}, 16'h0001);
    wr(4'h2, 16'h000D);
    cyc(2);
    chk({15'h0000, o_desat_clamp}, 16'h0000);
    @(posedge i_mclk);
    i_blanking <= 1'b1;
    cyc(2);
    chk({15'h0000, o_desat_clamp}, 16'h0001);
    @(posedge i_mclk);
    i_blanking <= 1'b0;
    i_output_off <= 1'b0;
    wr(4'h3, 16'h0300);
    cyc(0);
    chk({14'h0000, o_regular_hard_off, o_safe_hard_off}, 16'h0003);
    i_host_model.cfg_soft_off();
    cyc(0);
    chk({14'h0000, o_regular_hard_off, o_safe_hard_off}, 16'h0000);
    i_host_model.cfg_blank();
    cyc(2);
    chk({8'h00, o_desat_blank_time}, 16'h0020);
    @(posedge i_mclk);
    i_blank_select <= 1'b1;
    cyc(2);
    chk({8'h00, o_desat_blank_time}, 16'h0040);
    chk({7'h00, o_ocp_immediate, o_ocp_blank_time}, 16'h0010);
    wr(4'h7, 16'h0000);
    cyc(0);
    chk({15'h0000, o_ocp_immediate}, 16'h0001);
    rx(16'h0003, 1'b1);
    rx(16'h0007, 1'b0);
    wr(4'h1, 16'h0000);
    rx(16'h0003, 1'b0);
    tx(15'h0003, 16'h8003);
    tx(15'h0007, 16'h0007);
  endtask

  // Constant clamp levels, timed window and retrigger by turn-on.
  task automatic t_clamp();
    wr(4'h8, 16'h00FF);
    cyc(3);
    chk({15'h0000, o_clamp_disable}, 16'h0000);
    wr(4'h8, 16'h0000);
    cyc(3);
    chk({15'h0000, o_clamp_disable}, 16'h0001);
    wr(4'h8, 16'h0004);
    @(posedge i_mclk);
    i_hard_comm <= 1'b1;
    @(posedge i_mclk);
    i_hard_comm <= 1'b0;
    cyc(2);
    chk({15'h0000, o_clamp_disable}, 16'h0000);
    repeat (2) @(posedge i_mclk);
    i_turn_on <= 1'b1;
    @(posedge i_mclk);
    i_turn_on <= 1'b0;
    cyc(5);
    chk({15'h0000, o_clamp_disable}, 16'h0000);
    cyc(15);
    chk({15'h0000, o_clamp_disable}, 16'h0001);
  endtask

  // Freezing by the exit command, then locked writes and mode commands.
  task automatic t_freeze();
    wr(4'h0, 16'h0002);
    rdc(4'h0, 16'h0006);
    wr(4'h1, 16'h0001);
    wr(4'h2, 16'h0000);
    rdc(4'h2, 16'h000D);
    rdc(4'h1, 16'h0000);
    rdc(4'h0, 16'h0016);
    wr(4'h0, 16'h0001);
    rdc(4'h0, 16'h0006);
    chk({15'h0000, o_emitter_comp_en}, 16'h0001);
  endtask

  // Far-copy upset, reset event, then a delay calibration run.
  task automatic t_upset_calib();
    int n;
    n = 0;
    @(posedge i_mclk);
    i_mirror_upset <= 1'b1;
    @(posedge i_mclk);
    i_mirror_upset <= 1'b0;
    while (o_reset_event !== 1'b1 && n < 6) begin
      @(negedge i_mclk);
      n++;
    end
    chk({15'h0000, o_reset_event}, 16'h0001);
    chk({15'h0000, o_class_b}, 16'h0001);
    rdc(4'h0, 16'h0008);
    rdc(4'h2, 16'h0000);
    chk({13'h0000, o_emitter_comp_en, o_pulse_suppress_en,
         o_verify_timeout_sel}, 16'h0000);
    wr(4'h0, 16'h0001);
    wr(4'h2, 16'h000F);
    i_reset_event <= 1'b1;
    @(posedge i_mclk);
    i_reset_event <= 1'b0;
    rdc(4'h0, 16'h0008);
    rdc(4'h2, 16'h0000);
    i_host_model.start_calib();
    rdc(4'h0, 16'h000F);
    @(posedge i_mclk);
    i_pwm <= 1'b1;
    repeat (5) begin
      @(posedge i_mclk);
      i_osc_tick <= 1'b1;
      @(posedge i_mclk);
      i_osc_tick <= 1'b0;
    end
    @(posedge i_mclk);
    i_pwm <= 1'b0;
    cyc(3);
    rdc(4'h3, 16'h0005);
    rdc(4'h0, 16'h002F);
  endtask

  // Cuts a hang short.
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      stop_test();
    end
  end

  // Main sequence.
  initial begin
    failures = 0;
    checked = 0;
    cycles = 0;
    i_srst = 1'b1;
    {i_rx_valid, i_tx_valid, i_reset_event, i_mirror_upset} = 4'h0;
    {i_output_off, i_blanking, i_blank_select, i_hard_comm} = 4'h0;
    {i_turn_on, i_pwm, i_osc_tick} = 3'h0;
    i_rx_word = 16'h0000;
    i_tx_data = 15'h0000;
    repeat (6) @(posedge i_mclk);
    i_srst <= 1'b0;
    t_defaults();
    t_config();
    t_clamp();
    t_freeze();
    t_upset_calib();
    stop_test();
  end
endmodule // testbench
